// ### logic/wwdt_core.sv
// windowed watchdog timer: registers, 24-bit down counter, events
`timescale 1ns/1ps

module wwdt_core
  import wwdt_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic rc_osc_in,
  input wire logic [7:0] addr,
  input wire logic [31:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [31:0] rd_data,
  output logic irq,
  output logic chip_rst,
  output logic wdt_ovf
);

  wwdt_core_t q_reg;
  wwdt_core_t q_next;
  logic osc_tick;
  logic count_tick;

  // oscillator edges into the system clock domain
  wwdt_sync u_sync (
    .sys_clk(sys_clk),
    .rst(rst),
    .ce(ce),
    .async_in(rc_osc_in),
    .rise_pulse(osc_tick)
  );

  // count clock selection
  wwdt_presc u_presc (
    .sys_clk(sys_clk),
    .rst(rst),
    .ce(ce),
    .osc_tick(osc_tick),
    .sel(q_reg.sel),
    .count_tick(count_tick)
  );

  // next state: counting, events, register writes and reads
  always_comb begin
    logic [1:0] evt;
    logic [1:0] clr;
    logic [23:0] dec;
    evt = WWDT_EVT_NONE;
    clr = WWDT_EVT_NONE;
    dec = q_reg.count - WWDT_COUNT_ONE;
    q_next = q_reg;
    q_next.chip_rst = 1'b0;
    q_next.ovf = 1'b0;
    q_next.rd_data = '0;

    // down counting while enabled
    if (q_reg.en && count_tick) begin
      if (q_reg.count == WWDT_COUNT_ZERO) begin
        q_next.count = q_reg.reload;
        q_next.ovf = 1'b1;
        if (q_reg.mode_irq) begin
          evt[WWDT_EVT_UNDER_BIT] = 1'b1;
        end else begin
          q_next.chip_rst = 1'b1;
        end
      end else begin
        q_next.count = dec;
        if (dec == q_reg.window) begin
          evt[WWDT_EVT_WIN_BIT] = 1'b1;
        end
      end
    end

    // register writes
    if (wr_en) begin
      unique case (addr)
        WWDT_OFS_CTRL: begin
          q_next.en = wr_data[WWDT_CTRL_EN_BIT];
          q_next.mode_irq = wr_data[WWDT_CTRL_MODE_BIT];
          q_next.sel = wr_data[WWDT_CTRL_SEL_LSB +: WWDT_SEL_W];
          if (wr_data[WWDT_CTRL_EN_BIT] && !q_reg.en) begin
            q_next.count = q_reg.reload;
          end
        end
        WWDT_OFS_RELOAD: q_next.reload = wr_data[WWDT_CNT_W-1:0];
        WWDT_OFS_WINDOW: q_next.window = wr_data[WWDT_CNT_W-1:0];
        WWDT_OFS_COUNT: begin
          // refresh beats a same-cycle tick: no underflow, no events
          q_next.count = q_reg.reload;
          q_next.ovf = 1'b0;
          q_next.chip_rst = 1'b0;
          evt = WWDT_EVT_NONE;
        end
        WWDT_OFS_STATUS: clr = wr_data[WWDT_EVT_W-1:0];
        WWDT_OFS_MASK: q_next.mask = wr_data[WWDT_EVT_W-1:0];
        default: begin
        end
      endcase
    end

    // sticky status, a new event beats a same-cycle clear
    q_next.status = (q_reg.status & ~clr) | evt;
    q_next.irq = |(q_next.status & q_next.mask);

    // register reads, data stand the following cycle
    if (rd_en) begin
      unique case (addr)
        WWDT_OFS_CTRL: begin
          q_next.rd_data[WWDT_CTRL_EN_BIT] = q_reg.en;
          q_next.rd_data[WWDT_CTRL_MODE_BIT] = q_reg.mode_irq;
          q_next.rd_data[WWDT_CTRL_SEL_LSB +: WWDT_SEL_W] = q_reg.sel;
        end
        WWDT_OFS_RELOAD: q_next.rd_data[WWDT_CNT_W-1:0] = q_reg.reload;
        WWDT_OFS_WINDOW: q_next.rd_data[WWDT_CNT_W-1:0] = q_reg.window;
        WWDT_OFS_COUNT: q_next.rd_data[WWDT_CNT_W-1:0] = q_reg.count;
        WWDT_OFS_STATUS: q_next.rd_data[WWDT_EVT_W-1:0] = q_reg.status;
        WWDT_OFS_MASK: q_next.rd_data[WWDT_EVT_W-1:0] = q_reg.mask;
        default: q_next.rd_data = '0;
      endcase
    end
  end

  // state register, frozen while ce is low
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      q_reg <= '0;
      q_reg.reload <= WWDT_RELOAD_RST;
      q_reg.window <= WWDT_WINDOW_RST;
      q_reg.count <= WWDT_COUNT_RST;
    end else if (ce) begin
      q_reg <= q_next;
    end
  end

  // outputs straight from the state register
  assign rd_data = q_reg.rd_data;
  assign irq = q_reg.irq;
  assign chip_rst = q_reg.chip_rst;
  assign wdt_ovf = q_reg.ovf;

endmodule : wwdt_core

// ### logic/wwdt_pkg.sv
// constants and types shared by the windowed watchdog timer modules
package wwdt_pkg;

  // register bus geometry
  localparam int unsigned WWDT_ADDR_W = 8;
  localparam int unsigned WWDT_DATA_W = 32;

  // watchdog counter width
  localparam int unsigned WWDT_CNT_W = 24;

  // register byte offsets
  localparam logic [7:0] WWDT_OFS_CTRL = 8'h00;
  localparam logic [7:0] WWDT_OFS_RELOAD = 8'h04;
  localparam logic [7:0] WWDT_OFS_WINDOW = 8'h08;
  localparam logic [7:0] WWDT_OFS_COUNT = 8'h0C;
  localparam logic [7:0] WWDT_OFS_STATUS = 8'h10;
  localparam logic [7:0] WWDT_OFS_MASK = 8'h14;

  // control register fields
  localparam int unsigned WWDT_CTRL_EN_BIT = 0;
  localparam int unsigned WWDT_CTRL_MODE_BIT = 1;
  localparam int unsigned WWDT_CTRL_SEL_LSB = 2;
  localparam int unsigned WWDT_SEL_W = 2;

  // status and mask fields
  localparam int unsigned WWDT_EVT_W = 2;
  localparam int unsigned WWDT_EVT_UNDER_BIT = 0;
  localparam int unsigned WWDT_EVT_WIN_BIT = 1;

  // reset values and fixed count and event constants
  localparam logic [23:0] WWDT_RELOAD_RST = 24'hFFFFFF;
  localparam logic [23:0] WWDT_WINDOW_RST = 24'h000000;
  localparam logic [23:0] WWDT_COUNT_RST = 24'hFFFFFF;
  localparam logic [23:0] WWDT_COUNT_ZERO = 24'h000000;
  localparam logic [23:0] WWDT_COUNT_ONE = 24'h000001;
  localparam logic [1:0] WWDT_EVT_NONE = 2'h0;

  // count clock prescaler: divide by 1, 4, 16 or 64 oscillator edges
  localparam int unsigned WWDT_PRE_W = 6;
  localparam logic [1:0] WWDT_SEL_DIV1 = 2'h0;
  localparam logic [1:0] WWDT_SEL_DIV4 = 2'h1;
  localparam logic [1:0] WWDT_SEL_DIV16 = 2'h2;
  localparam logic [5:0] WWDT_MASK_DIV1 = 6'h00;
  localparam logic [5:0] WWDT_MASK_DIV4 = 6'h03;
  localparam logic [5:0] WWDT_MASK_DIV16 = 6'h0F;
  localparam logic [5:0] WWDT_MASK_DIV64 = 6'h3F;
  localparam logic [5:0] WWDT_PRE_ONE = 6'h01;

  // state of the oscillator edge synchroniser
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic pulse;
  } wwdt_sync_t;

  // state of the count clock prescaler
  typedef struct packed {
    logic [5:0] cnt;
    logic tick;
  } wwdt_pre_t;

  // state of the watchdog core
  typedef struct packed {
    logic en;
    logic mode_irq;
    logic [1:0] sel;
    logic [23:0] reload;
    logic [23:0] window;
    logic [23:0] count;
    logic [1:0] status;
    logic [1:0] mask;
    logic [31:0] rd_data;
    logic irq;
    logic chip_rst;
    logic ovf;
  } wwdt_core_t;

endpackage : wwdt_pkg

// ### logic/wwdt_sync.sv
// two-flop synchroniser with rising edge pulse for the rc oscillator
`timescale 1ns/1ps
module wwdt_sync
  import wwdt_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic async_in,
  output logic rise_pulse
);

  wwdt_sync_t q_reg;
  wwdt_sync_t q_next;

  // edge detect looks only at the second and third stages
  always_comb begin
    q_next = q_reg;
    q_next.s1 = async_in;
    q_next.s2 = q_reg.s1;
    q_next.s3 = q_reg.s2;
    q_next.pulse = q_reg.s2 & ~q_reg.s3;
  end

  // state register, frozen while ce is low
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      q_reg <= '0;
    end else if (ce) begin
      q_reg <= q_next;
    end
  end

  assign rise_pulse = q_reg.pulse;

endmodule : wwdt_sync

// ### logic/wwdt_presc.sv
// selectable divider making the watchdog count clock tick
`timescale 1ns/1ps
module wwdt_presc
  import wwdt_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic osc_tick,
  input wire logic [1:0] sel,
  output logic count_tick
);

  wwdt_pre_t q_reg;
  wwdt_pre_t q_next;
  logic [5:0] div_mask;

  // terminal mask per selected divide ratio
  always_comb begin
    unique case (sel)
      WWDT_SEL_DIV1: div_mask = WWDT_MASK_DIV1;
      WWDT_SEL_DIV4: div_mask = WWDT_MASK_DIV4;
      WWDT_SEL_DIV16: div_mask = WWDT_MASK_DIV16;
      default: div_mask = WWDT_MASK_DIV64;
    endcase
  end

  // count oscillator edges, tick once per full divide period
  always_comb begin
    q_next = q_reg;
    q_next.tick = 1'b0;
    if (osc_tick) begin
      q_next.cnt = q_reg.cnt + WWDT_PRE_ONE;
      q_next.tick = ((q_reg.cnt & div_mask) == div_mask);
    end
  end

  // state register, frozen while ce is low
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      q_reg <= '0;
    end else if (ce) begin
      q_reg <= q_next;
    end
  end

  assign count_tick = q_reg.tick;

endmodule : wwdt_presc

// ### test/wwdt_sys_model.sv
// reset and overflow logic model beside the watchdog, with its rc source
`timescale 1ns/1ps
module wwdt_sys_model (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic chip_rst,
  input wire logic wdt_ovf,
  output logic rc_osc_in,
  output logic [31:0] ovf_cnt,
  output logic [31:0] rst_cnt,
  output logic [31:0] gap
);
  logic [31:0] cyc;
  logic [31:0] last;
  logic ovf_prev;
  logic rst_prev;
  // rc source, seven clock periods, off the clock edges
  initial begin
    rc_osc_in = 1'b0;
    #3;
    forever #70 rc_osc_in = ~rc_osc_in;
  end
  // counts rising edges of reset and overflow, so a frozen pulse counts once
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      {cyc, last, ovf_cnt, rst_cnt, gap, ovf_prev, rst_prev} <= '0;
    end else begin
      cyc <= cyc + 1;
      ovf_prev <= wdt_ovf;
      rst_prev <= chip_rst;
      rst_cnt <= rst_cnt + 32'(chip_rst & ~rst_prev);
      if (wdt_ovf && !ovf_prev) begin
        ovf_cnt <= ovf_cnt + 1;
        gap <= cyc - last;
        last <= cyc;
      end
    end
  end
endmodule : wwdt_sys_model

// ### test/wwdt_checker.sv
// port assertions for the watchdog core
`timescale 1ns/1ps
module wwdt_checker
  import wwdt_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [7:0] addr,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [31:0] rd_data,
  input wire logic chip_rst,
  input wire logic wdt_ovf
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // pulse widths and pairing
  a_ovf_pulse: assert property (wdt_ovf && ce |=> !wdt_ovf) else $error("ovf too wide");
  a_rst_ovf: assert property (chip_rst |-> wdt_ovf) else $error("reset without ovf");
  a_rst_pulse: assert property (chip_rst && ce |=> !chip_rst) else $error("reset too wide");
  a_ovf_ce: assert property ($rose(wdt_ovf) |-> $past(ce)) else $error("ovf while frozen");
  // bus side and ce freeze
  a_count_width: assert property (rd_en && ce && addr == WWDT_OFS_COUNT |=>
    rd_data[31:24] == 8'h00) else $error("count wider than 24");
  a_refresh_wins: assert property (wr_en && ce && addr == WWDT_OFS_COUNT |=> !wdt_ovf)
    else $error("ovf after refresh");
  a_rd_idle: assert property (!rd_en && ce |=> rd_data == 32'h0) else $error("rd stuck");
  a_freeze: assert property (!ce |=> $stable({chip_rst, wdt_ovf})) else $error("not frozen");
endmodule : wwdt_checker
bind wwdt_core wwdt_checker wwdt_checker_inst (.sys_clk, .rst, .ce, .addr, .wr_en, .rd_en,
  .rd_data, .chip_rst, .wdt_ovf);

// ### test/tb.sv
// self-checking testbench for the watchdog core
`timescale 1ns/1ps
module tb;
  import wwdt_pkg::*;
  logic sys_clk, rst, ce, rc_osc_in, wr_en, rd_en, irq, chip_rst, wdt_ovf;
  logic [7:0] addr;
  logic [31:0] wr_data, rd_data, ovf_cnt, rst_cnt, gap;
  int bad_count, samples_checked;
  wwdt_core wwdt_core_inst (.sys_clk, .rst, .ce, .rc_osc_in, .addr, .wr_data, .wr_en,
    .rd_en, .rd_data, .irq, .chip_rst, .wdt_ovf);
  wwdt_sys_model wwdt_sys_model_inst (.sys_clk, .rst, .chip_rst, .wdt_ovf, .rc_osc_in,
    .ovf_cnt, .rst_cnt, .gap);
  // 50 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge sys_clk);
    wr_en <= 1'b0;
  endtask : wr
  task rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge sys_clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge sys_clk);
    rd_en <= 1'b0;
    @(negedge sys_clk);
    chk(rd_data, e);
  endtask : rd
  // waits for k overflow pulses, bounded
  task wait_ovf(input int k);
    logic [31:0] n0;
    n0 = ovf_cnt;
    repeat (5000) if (ovf_cnt - n0 < k) @(posedge sys_clk);
    chk(ovf_cnt - n0, k);
  endtask : wait_ovf
  task t_reset();
    rd(WWDT_OFS_RELOAD, 32'h00FFFFFF);
    rd(WWDT_OFS_COUNT, 32'h00FFFFFF);
    rd(8'h18, 32'h0);
    $display("reset test done");
  endtask : t_reset
  task t_window();
    wr(WWDT_OFS_RELOAD, 32'h2);
    wr(WWDT_OFS_WINDOW, 32'h1);
    wr(WWDT_OFS_MASK, 32'h3);
    wr(WWDT_OFS_CTRL, 32'h3);
    repeat (100) if (irq !== 1'b1) @(posedge sys_clk);
    chk(32'(irq), 32'h1);
    rd(WWDT_OFS_STATUS, 32'h2);
    wait_ovf(1);
    rd(WWDT_OFS_STATUS, 32'h3);
    chk(rst_cnt, 32'h0);
    $display("window test done");
  endtask : t_window
  task t_period();
    for (int s = 0; s < 4; s++) begin
      wr(WWDT_OFS_CTRL, 32'(s * 4 + 3));
      wait_ovf(3);
      chk(gap, 32'(21 << (2 * s)));
    end
    wr(WWDT_OFS_CTRL, 32'h3);
    $display("period test done");
  endtask : t_period
  task t_hold();
    logic [31:0] n;
    wr(WWDT_OFS_COUNT, 32'h0);
    ce <= 1'b0;
    repeat (2) @(posedge sys_clk);
    n = ovf_cnt;
    repeat (40) @(posedge sys_clk);
    ce <= 1'b1;
    chk(ovf_cnt, n);
    repeat (10) wr(WWDT_OFS_COUNT, 32'h0);
    chk(ovf_cnt, n);
    $display("hold test done");
  endtask : t_hold
  task t_rst_mode();
    logic [31:0] n;
    wr(WWDT_OFS_CTRL, 32'h0);
    wr(WWDT_OFS_STATUS, 32'h3);
    rd(WWDT_OFS_STATUS, 32'h0);
    chk(32'(irq), 32'h0);
    n = rst_cnt;
    wr(WWDT_OFS_CTRL, 32'h1);
    repeat (100) if (rst_cnt == n) @(posedge sys_clk);
    chk(rst_cnt - n, 32'h1);
    rd(WWDT_OFS_STATUS, 32'h2);
    $display("reset mode test done");
  endtask : t_rst_mode
  task summarize();
    $display("checked %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : summarize
  // watchdog for a hung run
  initial begin
    repeat (30000) @(posedge sys_clk);
    bad_count++;
    summarize();
  end
  initial begin
    {rst, ce, addr, wr_data, wr_en, rd_en} = {1'b1, 1'b1, 8'h0, 32'h0, 2'b00};
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    t_reset();
    t_window();
    t_period();
    t_hold();
    t_rst_mode();
    summarize();
  end
endmodule : tb
